// *** design/uart_tx_channel.sv ***
// Asynchronous serial transmit channel with an AHB-Lite register slave
`timescale 1ns/1ps
module uart_tx_channel #(
  parameter bit nine_bit_ok = 1'b1
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Serial line
  output logic             txd,
  output logic             txd_oe,
  // Transmit interrupt pulse
  output logic             tx_interrupt
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        take;
  logic        wr_data, wr_mode, wr_ctl;

  // Software register and state storage, read back by the bus slave
  logic [15:0]           channel_data_register_q, channel_data_register_d;
  uart_tx_pkg::mode_type mode_q, mode_d, mode_wr;
  logic                  running_q, running_d;
  logic                  output_enable_bits_q, output_enable_bits_d;
  logic                  serial_output_bits_q, serial_output_bits_d;
  logic                  buffer_full_flag_q, buffer_full_flag_d;
  logic                  load;
  logic                  line_drive;
  logic                  line_level;
  uart_tx_pkg::state_type state_q, state_d;

  assign take = hsel & hready & htrans[1];

  // Capture write address phases; build read data ahead of data phase
  always_comb begin
    wr_pend_d = take & hwrite;
    wr_addr_d = take ? {haddr[7:2], 2'b00} : wr_addr_q;
    rdata_d   = rdata_q;
    if (take && !hwrite) begin
      rdata_d = 32'h0000_0000;
      case ({haddr[7:2], 2'b00})
        uart_tx_pkg::data_offset: begin
          rdata_d[15:0] = channel_data_register_q;
        end
        uart_tx_pkg::mode_offset: begin
          rdata_d[9:0] = mode_q;
        end
        uart_tx_pkg::control_offset: begin
          rdata_d[uart_tx_pkg::ctl_start]  = running_q;
          rdata_d[uart_tx_pkg::ctl_level]  = serial_output_bits_q;
          rdata_d[uart_tx_pkg::ctl_enable] = output_enable_bits_q;
        end
        uart_tx_pkg::status_offset: begin
          rdata_d[uart_tx_pkg::sts_full] = buffer_full_flag_q;
          rdata_d[uart_tx_pkg::sts_busy] = (state_q != uart_tx_pkg::st_idle);
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  assign wr_data = wr_pend_q & (wr_addr_q == uart_tx_pkg::data_offset);
  assign wr_mode = wr_pend_q & (wr_addr_q == uart_tx_pkg::mode_offset);
  assign wr_ctl  = wr_pend_q & (wr_addr_q == uart_tx_pkg::control_offset);

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Register writes; a data write holds off the buffer load in its cycle and sets full
  always_comb begin
    channel_data_register_d = channel_data_register_q;
    mode_d                  = mode_q;
    running_d               = running_q;
    output_enable_bits_d    = output_enable_bits_q;
    serial_output_bits_d    = serial_output_bits_q;
    buffer_full_flag_d      = buffer_full_flag_q;
    mode_wr                 = uart_tx_pkg::mode_type'(hwdata[9:0]);
    if (!nine_bit_ok && mode_wr.len == uart_tx_pkg::len_9) begin
      mode_wr.len = uart_tx_pkg::len_8;
    end
    if (load) begin
      buffer_full_flag_d = 1'b0;
    end
    if (wr_data) begin
      channel_data_register_d = hwdata[15:0];
      buffer_full_flag_d      = 1'b1;
    end
    if (wr_mode) begin
      mode_d = mode_wr;
    end
    if (wr_ctl) begin
      output_enable_bits_d = hwdata[uart_tx_pkg::ctl_enable];
      if (hwdata[uart_tx_pkg::ctl_start]) begin
        running_d = 1'b1;
      end
      if (hwdata[uart_tx_pkg::ctl_stop]) begin
        running_d = 1'b0;
      end
    end
    // Line level: software preset while idle, frame bits while sending
    if (line_drive) begin
      serial_output_bits_d = line_level;
    end else if (wr_ctl) begin
      serial_output_bits_d = hwdata[uart_tx_pkg::ctl_level];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_data_register_q <= uart_tx_pkg::data_reset;
      mode_q                  <= uart_tx_pkg::mode_reset;
      running_q               <= 1'b0;
      output_enable_bits_q    <= 1'b0;
      serial_output_bits_q    <= uart_tx_pkg::level_reset;
      buffer_full_flag_q      <= 1'b0;
    end else begin
      channel_data_register_q <= channel_data_register_d;
      mode_q                  <= mode_d;
      running_q               <= running_d;
      output_enable_bits_q    <= output_enable_bits_d;
      serial_output_bits_q    <= serial_output_bits_d;
      buffer_full_flag_q      <= buffer_full_flag_d;
    end
  end

  // Drive the line only; reception belongs to the odd partner channel
  assign txd    = serial_output_bits_q;
  assign txd_oe = output_enable_bits_q;

  // ****************************************************************
  // Frame shifter
  // ****************************************************************
  logic [8:0]  shift_q, shift_d;
  logic [6:0]  div_q, div_d;
  logic [7:0]  baud_q, baud_d;
  logic [3:0]  idx_q, idx_d;
  logic        irq_q, irq_d;
  logic [3:0]  nbits;
  logic [3:0]  pos;
  logic [8:0]  mask;
  logic        bit_end;
  logic        data_bit;
  logic        par_bit;
  logic        enabled;

  // Only a pair set to the serial port function may transmit
  assign enabled = running_q &
                   (mode_q.func == uart_tx_pkg::func_uart);

  // Data length and data mask for the selected length
  always_comb begin
    case (mode_q.len)
      uart_tx_pkg::len_7: begin
        nbits = 4'd7;
        mask  = 9'h07F;
      end
      uart_tx_pkg::len_9: begin
        nbits = 4'd9;
        mask  = 9'h1FF;
      end
      default: begin
        nbits = 4'd8;
        mask  = 9'h0FF;
      end
    endcase
  end

  // Bit number sent in this slot, LSB or MSB first
  assign pos      = mode_q.lsb_first ? idx_q : nbits - 4'd1 - idx_q;
  assign data_bit = shift_q[pos];
  assign bit_end  = (baud_q == {div_q, 1'b1});

  // Parity over the sent data bits
  always_comb begin
    case (mode_q.parity)
      uart_tx_pkg::par_even: par_bit = ^(shift_q & mask);
      uart_tx_pkg::par_odd:  par_bit = ~^(shift_q & mask);
      default:               par_bit = 1'b0;
    endcase
  end

  // Logical bit of the current slot, then polarity
  always_comb begin
    case (state_q)
      uart_tx_pkg::st_start:  line_level = 1'b0;
      uart_tx_pkg::st_data:   line_level = data_bit;
      uart_tx_pkg::st_parity: line_level = par_bit;
      default:                line_level = 1'b1;
    endcase
    line_level = line_level ^ mode_q.invert;
  end

  assign line_drive = (state_q != uart_tx_pkg::st_idle);
  assign load = enabled & buffer_full_flag_q & ~wr_data &
                ((state_q == uart_tx_pkg::st_idle) ||
                 (state_q == uart_tx_pkg::st_stop && bit_end &&
                  idx_q[0] == mode_q.stop2 && mode_q.cont));

  // Frame sequencing; each bit lasts (divider + 1) * 2 clocks
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    div_d   = div_q;
    baud_d  = bit_end ? 8'h00 : baud_q + 8'h01;
    idx_d   = idx_q;
    irq_d   = 1'b0;
    case (state_q)
      uart_tx_pkg::st_idle: begin
        baud_d = 8'h00;
      end
      uart_tx_pkg::st_start: begin
        if (bit_end) begin
          state_d = uart_tx_pkg::st_data;
          idx_d   = 4'd0;
        end
      end
      uart_tx_pkg::st_data: begin
        if (bit_end) begin
          idx_d = idx_q + 4'd1;
          if (idx_q == nbits - 4'd1) begin
            idx_d   = 4'd0;
            state_d = (mode_q.parity == uart_tx_pkg::par_none) ?
                      uart_tx_pkg::st_stop : uart_tx_pkg::st_parity;
          end
        end
      end
      uart_tx_pkg::st_parity: begin
        if (bit_end) begin
          state_d = uart_tx_pkg::st_stop;
          idx_d   = 4'd0;
        end
      end
      uart_tx_pkg::st_stop: begin
        if (bit_end) begin
          idx_d = idx_q + 4'd1;
          if (idx_q[0] == mode_q.stop2) begin
            state_d = uart_tx_pkg::st_idle;
            irq_d   = ~mode_q.cont;
          end
        end
      end
      default: begin
        state_d = uart_tx_pkg::st_idle;
      end
    endcase
    if (!enabled) begin
      state_d = uart_tx_pkg::st_idle;
    end
    if (load) begin
      state_d = uart_tx_pkg::st_start;
      shift_d = channel_data_register_q[uart_tx_pkg::data_msb:
                                        uart_tx_pkg::data_lsb];
      div_d   = channel_data_register_q[uart_tx_pkg::div_msb:
                                        uart_tx_pkg::div_lsb];
      baud_d  = 8'h00;
      idx_d   = 4'd0;
      irq_d   = mode_q.cont;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= uart_tx_pkg::st_idle;
      shift_q <= 9'h000;
      div_q   <= 7'h00;
      baud_q  <= 8'h00;
      idx_q   <= 4'h0;
      irq_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      div_q   <= div_d;
      baud_q  <= baud_d;
      idx_q   <= idx_d;
      irq_q   <= irq_d;
    end
  end

  assign tx_interrupt = irq_q;

endmodule

// *** common/uart_tx_pkg.sv ***
// Constants and types for the asynchronous serial transmit channel
// ****************************************************************
// Behaviour
// - Frame is start, data, parity, stop bits
// - Even channel of the pair transmits
// - Odd partner channel alone handles reception
// - Data length seven, eight or nine bits
// - Nine bits only on instances allowing it
// - Nine-bit frame takes data bits 0 to 8
// - Data shifted MSB first or LSB first
// - Normal idles high; inverted flips every frame bit, not the software preset idle level
// - Parity none, zero, even or odd
// - One or two stop bits appended
// - Interrupt at transfer end or buffer empty
// - Paired channels run only as serial port
// - Channel performs only its selected function
// - Receiver reports errors; transmitter has none
// - Stop bits appended on transmit
// ****************************************************************
package uart_tx_pkg;

  // Register byte offsets
  localparam logic [7:0] data_offset    = 8'h00;
  localparam logic [7:0] mode_offset    = 8'h04;
  localparam logic [7:0] control_offset = 8'h08;
  localparam logic [7:0] status_offset  = 8'h0C;

  // Field positions in the channel data register
  localparam int data_lsb = 0;
  localparam int data_msb = 8;
  localparam int div_lsb  = 9;
  localparam int div_msb  = 15;

  // Control register bits
  localparam int ctl_start  = 0;
  localparam int ctl_stop   = 1;
  localparam int ctl_level  = 2;
  localparam int ctl_enable = 3;

  // Status register bits
  localparam int sts_full = 0;
  localparam int sts_busy = 1;

  // Mode field encodings
  localparam logic [1:0] len_7     = 2'h0;
  localparam logic [1:0] len_8     = 2'h1;
  localparam logic [1:0] len_9     = 2'h2;
  localparam logic [1:0] par_none  = 2'h0;
  localparam logic [1:0] par_zero  = 2'h1;
  localparam logic [1:0] par_even  = 2'h2;
  localparam logic [1:0] par_odd   = 2'h3;
  localparam logic [1:0] func_off  = 2'h0;
  localparam logic [1:0] func_uart = 2'h1;

  // AHB transfer types
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq    = 2'h3;

  // Reset values
  localparam logic [15:0] data_reset  = 16'h0000;
  localparam logic [9:0]  mode_reset  = 10'h001;
  localparam logic        level_reset = 1'b1;

  // Frame configuration held in the mode register
  typedef struct packed {
    logic [1:0] func;
    logic       cont;
    logic       invert;
    logic       lsb_first;
    logic       stop2;
    logic [1:0] parity;
    logic [1:0] len;
  } mode_type;

  // Transmitter states
  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_start  = 3'b001,
    st_data   = 3'b010,
    st_parity = 3'b011,
    st_stop   = 3'b100
  } state_type;

endpackage

// *** verif/uart_line_model.sv ***
// Line-side receiver that samples each frame at mid-bit
`timescale 1ns/1ps
module uart_line_model (
  // Clock and line
  input  wire logic        hclk,
  input  wire logic        txd,
  // Frame shape
  input  wire logic        inv,
  input  wire logic [8:0]  bit_len,
  input  wire logic [3:0]  frame_len,
  // Received frame, first bit in bit 0
  output logic      [15:0] rx_word,
  output int               rx_count
);
  // Wait for an idle-to-start edge, then sample every bit time
  initial begin
    logic p;
    rx_word  = 16'h0000;
    rx_count = 0;
    forever begin
      p = txd;
      @(posedge hclk);
      if (p === ~inv && txd === inv) begin
        rx_word = 16'h0000;
        repeat (bit_len / 2) @(posedge hclk);
        for (int i = 0; i < frame_len; i++) begin
          rx_word[i] = txd;
          if (i < frame_len - 1)
            repeat (bit_len) @(posedge hclk);
        end
        rx_count++;
      end
    end
  end
endmodule

// *** verif/uart_tx_channel_properties.sv ***
// Assertions on the transmit channel's bus and line ports
`timescale 1ns/1ps
module uart_tx_channel_properties (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Line
  input wire logic        txd,
  input wire logic        txd_oe,
  input wire logic        tx_interrupt
);
  logic       wr_q, rd_q, last_q, inv_q, cont_q, fresh_q;
  logic [7:0] a_q;
  logic [8:0] hold_q, bit_q;
  wire        tk = hsel && hready && htrans[1];
  wire        dw = wr_q && a_q == 8'h00;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus phases, line hold count and programmed frame set-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, rd_q, inv_q, cont_q, fresh_q} <= 5'h00;
      last_q <= 1'b1;
      a_q    <= 8'h00;
      hold_q <= 9'h1FF;
      bit_q  <= 9'h002;
    end else begin
      wr_q   <= tk && hwrite;
      rd_q   <= tk && !hwrite;
      a_q    <= haddr[7:0] & 8'hFC;
      last_q <= txd;
      hold_q <= txd != last_q ? 9'h001 : hold_q + {8'h00, hold_q != 9'h1FF};
      if (dw)
        bit_q <= ({2'h0, hwdata[15:9]} + 9'h001) * 9'h002;
      if (wr_q && a_q == 8'h04) begin
        {cont_q, inv_q} <= hwdata[7:6];
        fresh_q <= 1'b1;
      end else if (dw)
        fresh_q <= 1'b0;
    end
  end
  // ********
  // Checks
  // ********
  bus_okay_a:
    assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not okay and ready");
  oe_follow_a:
    assert property (wr_q && a_q == 8'h08 |=> txd_oe == $past(hwdata[3]))
    else $error("output enable did not follow write");
  oe_readback_a:
    assert property (rd_q && a_q == 8'h08 |-> hrdata[3] == txd_oe)
    else $error("output enable read back wrong");
  unmapped_zero_a:
    assert property (rd_q && a_q == 8'h10 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  irq_pulse_a:
    assert property (tx_interrupt |=> !tx_interrupt)
    else $error("interrupt longer than one cycle");
  line_hold_a:
    assert property (txd != last_q |-> hold_q >= bit_q)
    else $error("line level held shorter than a bit");
  start_delay_a:
    assert property (dw && fresh_q && !cont_q |-> ##[2:4] txd == inv_q)
    else $error("start bit missing after data write");
  single_end_a:
    assert property (tx_interrupt && !cont_q |=>
      txd == !inv_q && hold_q >= bit_q)
    else $error("transfer end before stop bit done");
  cont_empty_a:
    assert property (dw && fresh_q && cont_q |-> ##[1:4] tx_interrupt)
    else $error("no buffer empty interrupt");
endmodule
bind uart_tx_channel uart_tx_channel_properties u_props (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata,
  .hresp, .txd, .txd_oe, .tx_interrupt);

// *** verif/uart_transmit_channel_test.sv ***
// Self-checking bench for the serial transmit channel
`timescale 1ns/1ps
module uart_transmit_channel_test;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, txd, txd_oe, tx_interrupt, inv = 1'b0;
  logic [8:0]  bit_len = 9'h006;
  logic [3:0]  frame_len = 4'hA;
  logic [15:0] rx_word;
  logic [6:0]  dv;
  logic [9:0]  m;
  int          rx_count, k, bad_count = 0, checks_done = 0, irqs = 0;
  logic [15:0] exp_q[$];
  wire         hready = hreadyout;
  uart_tx_channel u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .txd, .txd_oe,
    .tx_interrupt);
  uart_line_model u_line (.hclk, .txd, .inv, .bit_len, .frame_len,
    .rx_word, .rx_count);
  // Clock, interrupt count and frame comparison
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (tx_interrupt === 1'b1) irqs++;
  always @(rx_count) compare(rx_word, exp_q.pop_front());
  // ********
  // Tasks
  // ********
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Expected line levels of one frame, first bit in bit 0
  function automatic logic [15:0] frame(input logic [8:0] d,
      input logic [9:0] c, output logic [3:0] len);
    logic [15:0] f;
    logic        p;
    int          nb, j;
    nb = c[1:0] == 2'h0 ? 7 : c[1:0] == 2'h2 ? 9 : 8;
    f = 16'h0000;
    p = c[3:2] == 2'h3;
    j = 1;
    for (int i = 0; i < nb; i++) begin
      f[j] = d[c[5] ? i : nb - 1 - i];
      p ^= d[i];
      j++;
    end
    if (c[3:2] != 2'h0) begin
      f[j] = c[3:2] != 2'h1 && p;
      j++;
    end
    f[j] = 1'b1;
    f[j + 1] = 1'b1;
    len = 4'(j + 1 + int'(c[4]));
    return (c[6] ? ~f : f) & ((16'h1 << len) - 16'h1);
  endfunction
  task automatic send(input logic [9:0] c);
    logic [8:0] d;
    logic [3:0] n;
    d = 9'($urandom);
    exp_q.push_back(frame(d, c, n));
    frame_len = n;
    bus(1'b1, 8'h00, {16'h0, dv, d});
  endtask
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  // Main sequence
  initial begin
    void'($urandom(32'hDB65880A));
    dv = 7'h02 + 7'($urandom_range(3));
    bit_len = 9'(({2'h0, dv} + 9'h001) * 9'h002);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    compare(rd, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    compare(rd, 32'h4);
    bus(1'b0, 8'h10, 32'h0);
    compare(rd, 32'h0);
    bus(1'b1, 8'h08, 32'hD);
    for (int j = 0; j < 12; j++) begin
      m = {2'h1, 1'b0, j > 5, j[2] ^ j[0], j[2], j[1:0], 2'(j % 3)};
      bus(1'b1, 8'h04, {22'h0, m});
      inv = m[6];
      if (j == 6) begin
        bus(1'b1, 8'h08, 32'h9);
        repeat (bit_len) @(posedge hclk);
      end
      k = irqs;
      send(m);
      while (irqs == k) @(posedge hclk);
      bus(1'b0, 8'h0C, 32'h0);
      compare(rd, 32'h0);
    end
    m = 10'h1A1;
    bus(1'b1, 8'h04, {22'h0, m});
    inv = 1'b0;
    bus(1'b1, 8'h08, 32'hD);
    repeat (bit_len) @(posedge hclk);
    k = irqs;
    send(m);
    while (irqs == k) @(posedge hclk);
    k = irqs;
    send(m);
    void'(exp_q.pop_back());
    send(m);
    bus(1'b0, 8'h0C, 32'h0);
    compare(rd, 32'h3);
    while (irqs == k) @(posedge hclk);
    while (exp_q.size() != 0) @(posedge hclk);
    repeat (bit_len) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0);
    compare(rd, 32'h0);
    bus(1'b1, 8'h08, 32'hE);
    bus(1'b0, 8'h08, 32'h0);
    compare(rd, 32'hC);
    print_verdict;
  end
endmodule
